// File: hw/key_on_wakeup.v
// Key-on wakeup stop release logic with register port
//
// Notes on behaviour
// - Enable register at 0x0F9A; bits 7..4 enable the four key wake pins.
// - Each key wake pin has its own enable bit; disabled key pins never release stop. The stop pin has no enable bit.
// - Enable bits reset to zero; low four bits are undefined, read zero here.
// - Level mode: any enabled wake pin at low level releases stop.
// - Stop pin releases on high level when mode is 1, rising edge when 0.
// - Release condition present at stop entry skips stop and starts warm-up.
`include "wake_map.vh"
module key_on_wakeup #(
  parameter NUM_KEYS = 4
) (
  // Clock and reset
  input  wire        clk,
  input  wire        rstn,
  // Register port
  input  wire [15:0] addr,
  input  wire [7:0]  wdata,
  input  wire        wr,
  input  wire        rd,
  output reg  [7:0]  rdata,
  // Wake pins
  input  wire        stop_pin,
  input  wire        key_wake_pin_a,
  input  wire        key_wake_pin_b,
  input  wire        key_wake_pin_c,
  input  wire        key_wake_pin_d,
  // Power sequencing
  input  wire        stop_entry,
  output reg         in_stop,
  output reg         warmup_start
);
  localparam ST_RUN  = 2'b01;
  localparam ST_STOP = 2'b10;

  reg  [1:0]          state;
  reg  [1:0]          next_state;
  reg  [NUM_KEYS-1:0] key_wake_enable;
  reg                 level_mode;
  reg                 skipped;
  reg                 released;
  reg                 next_warmup;
  wire [NUM_KEYS-1:0] key_pins;
  wire                stop_hit;
  wire                key_hit;
  wire                release_req;

  assign key_pins = {key_wake_pin_d, key_wake_pin_c, key_wake_pin_b, key_wake_pin_a};

  stop_pin_detect u_stop_pin_detect (
    .clk         (clk),
    .rstn        (rstn),
    .stop_pin    (stop_pin),
    .level_mode  (level_mode),
    .armed       (state == ST_STOP),
    .release_hit (stop_hit)
  );

  // Key pins act only in level mode; edge mode leaves them unsupported
  assign key_hit     = level_mode & (|(key_wake_enable & ~key_pins));
  assign release_req = stop_hit | key_hit;

  // Register writes and control
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      key_wake_enable <= `KEY_WAKE_EN_RESET;
      level_mode      <= `LEVEL_MODE_RESET;
    end else if (wr) begin
      if (addr == `KEY_WAKE_ENABLE_ADDR) begin
        key_wake_enable <= wdata[`KEY_WAKE_EN_MSB:`KEY_WAKE_EN_LSB];
      end
      if (addr == `WAKE_CTRL_ADDR) begin
        level_mode <= wdata[0];
      end
    end
  end

  // Read port: enable register is write only and reads zero
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rdata <= 8'h00;
    end else if (rd) begin
      case (addr)
        `WAKE_STATUS_ADDR: rdata <= {5'h00, skipped, released, in_stop};
        `WAKE_CTRL_ADDR:   rdata <= {7'h00, level_mode};
        default:           rdata <= 8'h00;
      endcase
    end else begin
      rdata <= 8'h00;
    end
  end

  // Stop sequencer
  always @* begin
    next_state  = state;
    next_warmup = 1'b0;
    case (state)
      ST_RUN: begin
        if (stop_entry) begin
          if (stop_pin & level_mode | key_hit | stop_pin & ~level_mode) begin
            next_warmup = 1'b1;
          end else begin
            next_state = ST_STOP;
          end
        end
      end
      ST_STOP: begin
        if (release_req) begin
          next_state  = ST_RUN;
          next_warmup = 1'b1;
        end
      end
      default: begin
        next_state = ST_RUN;
      end
    endcase
  end

  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      state        <= ST_RUN;
      in_stop      <= 1'b0;
      warmup_start <= 1'b0;
      skipped      <= 1'b0;
      released     <= 1'b0;
    end else begin
      state        <= next_state;
      in_stop      <= (next_state == ST_STOP);
      warmup_start <= next_warmup;
      if (state == ST_RUN && stop_entry) begin
        skipped  <= next_warmup;
        released <= 1'b0;
      end else if (state == ST_STOP && release_req) begin
        released <= 1'b1;
      end
    end
  end
endmodule // key_on_wakeup

// File: common/wake_map.vh
// Address map, field positions and reset values of the key-on wakeup block
`ifndef WAKE_MAP_VH
`define WAKE_MAP_VH
`define KEY_WAKE_ENABLE_ADDR  16'h0f9a
`define KEY_WAKE_EN_LSB       4
`define KEY_WAKE_EN_MSB       7
`define KEY_WAKE_EN_RESET     4'h0
`define WAKE_STATUS_ADDR      16'h0f9b
`define WAKE_CTRL_ADDR        16'h0f9c
`define WAKE_CTRL_RESET       8'h01
`define LEVEL_MODE_RESET      1'b1
`endif

// File: hw/stop_pin_detect.v
// Stop pin release detector: high level or rising edge
module stop_pin_detect (
  // Clock and reset
  input  wire clk,
  input  wire rstn,
  // Pin and mode
  input  wire stop_pin,
  input  wire level_mode,
  input  wire armed,
  // Result
  output wire release_hit
);
  reg stop_pin_prev;

  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      stop_pin_prev <= 1'b0;
    end else begin
      stop_pin_prev <= stop_pin;
    end
  end

  // Edge mode only counts rises seen while stop is armed
  assign release_hit = level_mode ? stop_pin : (armed & stop_pin & ~stop_pin_prev);
endmodule // stop_pin_detect

// File: testbench/key_on_wakeup_sva.sv
// Port assertions for the key-on wakeup block
`include "wake_map.vh"
module key_on_wakeup_sva (
  input wire        clk, rstn, rd, stop_pin, stop_entry, in_stop, warmup_start,
  input wire        key_wake_pin_a, key_wake_pin_b, key_wake_pin_c, key_wake_pin_d,
  input wire [15:0] addr,
  input wire [7:0]  rdata
);
  timeunit 1ns;
  timeprecision 1ps;
  wire hi = key_wake_pin_a & key_wake_pin_b & key_wake_pin_c & key_wake_pin_d;
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  chk_skip_entry: assert property (stop_entry && stop_pin |=> warmup_start && !in_stop) else $error("skip");
  chk_enter_stop: assert property (stop_entry && !stop_pin && hi |=> in_stop && !warmup_start) else $error("enter");
  chk_pin_release: assert property (in_stop && stop_pin |=> !in_stop && warmup_start) else $error("pin");
  chk_hold_stop: assert property (in_stop && !stop_pin && hi |=> in_stop) else $error("hold");
  chk_quiet_run: assert property (!in_stop && !stop_entry |=> !warmup_start) else $error("spurious");
  chk_fall_pulse: assert property ($fell(in_stop) |-> warmup_start ##1 !warmup_start) else $error("pulse");
  chk_wo_read: assert property (rd && addr == `KEY_WAKE_ENABLE_ADDR |=> rdata == 8'h00) else $error("read");
  cover property (stop_entry ##1 in_stop);
  cover property (in_stop ##1 warmup_start);
  cover property (stop_entry ##1 warmup_start);
endmodule // key_on_wakeup_sva
bind key_on_wakeup key_on_wakeup_sva chk (.*);

// File: testbench/key_pad.sv
// Keys and stop switch on the wake pins
module key_pad (
  input  wire logic       clk,
  input  wire logic [4:0] press,
  output logic            stop_pin = 1'b0,
  output logic [3:0]      keys     = 4'hf
);
  timeunit 1ns;
  timeprecision 1ps;
  always @(posedge clk) begin
    stop_pin <= press[4];
    keys     <= ~press[3:0];
  end
endmodule // key_pad

// File: testbench/key_on_wakeup_bench.sv
// Self-checking bench for the key-on wakeup block
`include "wake_map.vh"
module key_on_wakeup_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk = 0, rstn = 0, wr = 0, rd = 0, stop_entry = 0;
  logic [15:0] addr = 0;
  logic [7:0]  wdata = 0;
  logic [4:0]  press = 0;
  logic [31:0] seed = 32'h8657;
  wire [7:0]   rdata;
  wire [3:0]   keys;
  wire         stop_pin, in_stop, warmup_start;
  int          err_total, checks_done, cyc;
  always #2.5 clk = ~clk;
  key_on_wakeup dut (.clk(clk), .rstn(rstn), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
    .stop_pin(stop_pin), .key_wake_pin_a(keys[0]), .key_wake_pin_b(keys[1]), .key_wake_pin_c(keys[2]),
    .key_wake_pin_d(keys[3]), .stop_entry(stop_entry), .in_stop(in_stop), .warmup_start(warmup_start));
  key_pad pad (.clk(clk), .press(press), .stop_pin(stop_pin), .keys(keys));
  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction
  task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp) begin
      err_total++;
      $display("Error %0t: got %h want %h", $time, got, exp);
    end
  endtask
  // Write when w, else read and compare against d
  task automatic bus(input logic w, input logic [15:0] a, input logic [7:0] d);
    @(posedge clk);
    {wr, rd, addr, wdata} <= {w, !w, a, d};
    @(posedge clk);
    {wr, rd} <= 2'b00;
    if (!w) #1 cmp(rdata, d);
  endtask
  task automatic enter(input logic exp);
    @(posedge clk) stop_entry <= 1;
    @(posedge clk) stop_entry <= 0;
    #1 cmp(in_stop, exp);
    cmp(warmup_start, !exp);
  endtask
  // Pad adds one cycle, design one more
  task automatic push(input logic [4:0] p, input logic exp);
    logic was;
    was = in_stop;
    @(posedge clk) press <= p;
    repeat (2) @(posedge clk);
    #1 cmp(in_stop, exp);
    cmp(warmup_start, was & !exp);
  endtask
  task automatic trial(input logic [3:0] en, input int k, input logic lvl, input logic cfg);
    logic rel;
    rel = (k == 4) || (lvl && en[k]);
    if (cfg) bus(1, `KEY_WAKE_ENABLE_ADDR, {en, 4'h0});
    if (cfg) bus(1, `WAKE_CTRL_ADDR, {7'h0, lvl});
    enter(1);
    push(5'h1 << k, !rel);
    push(5'h10, 0);
    push(5'h1 << k, 0);
    enter(!rel);
    push(5'h10, 0);
    push(0, 0);
  endtask
  task automatic end_of_test;
    $display("checks %0d errors %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  always @(posedge clk) if (++cyc > 5000) begin
    err_total++;
    end_of_test();
  end
  initial begin
    repeat (8) @(posedge clk);
    rstn <= 1;
    bus(0, `WAKE_STATUS_ADDR, 8'h00);
    bus(0, `KEY_WAKE_ENABLE_ADDR, 8'h00);
    bus(0, 16'h0f00, 8'h00);
    trial(4'h0, 0, 1, 0);
    for (int i = 0; i < 24; i++) begin
      seed = xs(seed);
      trial(seed[8] ? seed[3:0] : 4'h0, seed[7:4] % 5, seed[8], 1);
    end
    end_of_test();
  end
endmodule // key_on_wakeup_bench
